// File: hdl/mb_regs.svh
// constants for the serial slave request handler
`ifndef MB_REGS_SVH
`define MB_REGS_SVH

// =============================================================
// line timing
`define MB_CLK_HZ 125000000
`define MB_BAUD_BPS 19200
`define MB_BIT_CYC (`MB_CLK_HZ / `MB_BAUD_BPS)
`define MB_GAP15_HALF_BITS 33
`define MB_GAP35_HALF_BITS 77
`define MB_REPLY_LAT_MS 10
`define MB_REPLY_LAT_CYC (`MB_CLK_HZ / 1000 * `MB_REPLY_LAT_MS)

// =============================================================
// frame layout and codes
`define MB_FRAME_MAX 9'h100
`define MB_LEN_MIN 9'h004
`define MB_LEN_RD_HOLD 9'h008
`define MB_LEN_DT_SET 9'h00e
`define MB_LEN_HDR 9'h003
`define MB_LEN_DT_REPLY 9'h00c
`define MB_DT_OFS 9'h004
`define MB_ADDR_BCAST 8'h00
`define MB_ADDR_MAX 8'hf7
`define MB_ADDR_RESET 8'h01
`define MB_FC_RD_HOLD 8'h03
`define MB_FC_MEI 8'h2b
`define MB_SUB_ID 8'h0e
`define MB_SUB_DT_GET 8'h0f
`define MB_SUB_DT_SET 8'h10
`define MB_FC_EXC_BIT 8'h80
`define MB_EX_FUNC 8'h01
`define MB_EX_ADDR 8'h02
`define MB_EX_VALUE 8'h03
`define MB_EX_FAIL 8'h04
`define MB_RD_MAX 16'h007d
`define MB_ID_LEN 9'h008
`define MB_RSVD 8'h00
`define MB_CRC_INIT 16'hffff
`define MB_CRC_POLY 16'ha001
`define MB_CRC_RESIDUE 16'h0000

// =============================================================
// calendar limits
`define MB_MONTHS 8'h0c
`define MB_HOURS 8'h18
`define MB_MINUTES 8'h3c
`define MB_MS_PER_MIN 16'hea60

// =============================================================
// software registers
`define MB_REG_SLAVE_ADDR 8'h00
`define MB_REG_STATUS 8'h04
`define MB_REG_GOOD_FRAMES 8'h08
`define MB_ST_CRC_ERR 0
`define MB_ST_FRAME_ERR 1
`define MB_ST_BUSY 2

`endif

// File: hdl/mb_pkg.sv
// types shared by the serial slave request handler
package mb_pkg;
	typedef enum logic [2:0] {ST_RX, ST_DECODE, ST_FILL, ST_RDREQ, ST_RDWAIT,
		ST_RDLO, ST_TX, ST_TXWAIT} mb_state_t;
	typedef enum logic [2:0] {M_EXC, M_RDH, M_ID, M_DTGET, M_ECHO} mb_mode_t;
endpackage

// File: hdl/mb_crc.sv
// one byte step of the frame check
`timescale 1ns/100ps
`default_nettype none
`include "mb_regs.svh"
module mb_crc
(
	input wire logic [15:0] crc_in,
	input wire logic [7:0] data_in,
	output logic [15:0] crc_out
);
	always_comb
	begin
		crc_out = crc_in ^ {8'h00, data_in};
		for (int i = 0; i < 8; i++)
		begin
			if (crc_out[0])
				crc_out = (crc_out >> 1) ^ `MB_CRC_POLY;
			else
				crc_out = crc_out >> 1;
		end
	end
endmodule
`default_nettype wire

// File: hdl/mb_uart.sv
// 8E2 serial receiver and transmitter
`timescale 1ns/100ps
`default_nettype none
`include "mb_regs.svh"
module mb_uart
#(
	parameter int BIT_CYC = `MB_BIT_CYC
)
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic rx_in,
	input wire logic [7:0] tx_data_in,
	input wire logic tx_start_in,
	output logic rx_valid_out,
	output logic [7:0] rx_data_out,
	output logic rx_err_out,
	output logic tx_out,
	output logic tx_done_out
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg, lvl_next;
	logic rx_on_reg, rx_on_next;
	logic [15:0] rcnt_reg, rcnt_next, tcnt_reg, tcnt_next;
	logic [3:0] rbit_reg, rbit_next, tbit_reg, tbit_next;
	logic [11:0] rsh_reg, rsh_next, tsh_reg, tsh_next;
	logic rv_next, rerr_next, tx_next, tdone_next;
	logic [7:0] rdat_next;

	// =============================================================
	// next state
	always_comb
	begin
		lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
		rx_on_next = rx_on_reg;
		rcnt_next = rcnt_reg;
		rbit_next = rbit_reg;
		rsh_next = rsh_reg;
		rv_next = 1'b0;
		rerr_next = rx_err_out;
		rdat_next = rx_data_out;
		if (!rx_on_reg)
		begin
			if (!lvl_reg)
			begin
				rx_on_next = 1'b1;
				rcnt_next = 16'(BIT_CYC / 2);
				rbit_next = 4'h0;
			end
		end
		else if (rcnt_reg != 16'h0000)
			rcnt_next = rcnt_reg - 16'h0001;
		else
		begin
			rsh_next = {lvl_reg, rsh_reg[11:1]};
			rcnt_next = 16'(BIT_CYC - 1);
			rbit_next = rbit_reg + 4'h1;
			if (rbit_reg == 4'hb)
			begin
				// even parity over data plus parity bit, both stops high
				rx_on_next = 1'b0;
				rv_next = 1'b1;
				rdat_next = rsh_next[8:1];
				rerr_next = rsh_next[0] | (^rsh_next[9:1]) | ~rsh_next[10]
					| ~rsh_next[11];
			end
		end
		tsh_next = tsh_reg;
		tcnt_next = tcnt_reg;
		tbit_next = tbit_reg;
		tx_next = tx_out;
		tdone_next = 1'b0;
		if (tbit_reg == 4'h0)
		begin
			if (tx_start_in)
			begin
				tsh_next = {2'b11, ^tx_data_in, tx_data_in, 1'b0};
				// one step more than bits sent: holds the second stop a full bit
				tbit_next = 4'hd;
				tcnt_next = 16'h0000;
			end
		end
		else if (tcnt_reg != 16'h0000)
			tcnt_next = tcnt_reg - 16'h0001;
		else
		begin
			tx_next = tsh_reg[0];
			tsh_next = {1'b1, tsh_reg[11:1]};
			tcnt_next = 16'(BIT_CYC - 1);
			tbit_next = tbit_reg - 4'h1;
		end
		if (tbit_reg == 4'h1 && tcnt_reg == 16'h0001)
			tdone_next = 1'b1;
	end

	// =============================================================
	// registers
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s1_reg <= 1'b1;
			s2_reg <= 1'b1;
			s3_reg <= 1'b1;
			lvl_reg <= 1'b1;
			rx_on_reg <= 1'b0;
			rcnt_reg <= 16'h0000;
			rbit_reg <= 4'h0;
			rsh_reg <= 12'h000;
			rx_valid_out <= 1'b0;
			rx_err_out <= 1'b0;
			rx_data_out <= 8'h00;
			tsh_reg <= 12'hfff;
			tcnt_reg <= 16'h0000;
			tbit_reg <= 4'h0;
			tx_out <= 1'b1;
			tx_done_out <= 1'b0;
		end
		else
		begin
			s1_reg <= rx_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= lvl_next;
			rx_on_reg <= rx_on_next;
			rcnt_reg <= rcnt_next;
			rbit_reg <= rbit_next;
			rsh_reg <= rsh_next;
			rx_valid_out <= rv_next;
			rx_err_out <= rerr_next;
			rx_data_out <= rdat_next;
			tsh_reg <= tsh_next;
			tcnt_reg <= tcnt_next;
			tbit_reg <= tbit_next;
			tx_out <= tx_next;
			tx_done_out <= tdone_next;
		end
	end
endmodule
`default_nettype wire

// File: hdl/mb_slave.sv
// serial slave request handler: framing, decode, reply
`timescale 1ns/100ps
`default_nettype none
`include "mb_regs.svh"
module mb_slave
	import mb_pkg::*;
#(
	parameter int BIT_CYC = `MB_BIT_CYC,
	parameter int REPLY_LAT_CYC = `MB_REPLY_LAT_CYC
)
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic rx_in,
	output logic tx_out,
	output logic tx_en_out,
	input wire logic [7:0] reg_addr_in,
	input wire logic [31:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [31:0] reg_rdata_out,
	output logic hreg_req_out,
	output logic [15:0] hreg_addr_out,
	input wire logic hreg_ack_in,
	input wire logic hreg_err_in,
	input wire logic [15:0] hreg_data_in,
	output logic [7:0] id_index_out,
	input wire logic [7:0] id_byte_in,
	input wire logic [63:0] dt_now_in,
	output logic dt_load_out,
	output logic [63:0] dt_value_out
);
	localparam logic [20:0] GAP15 = 21'(BIT_CYC * `MB_GAP15_HALF_BITS / 2);
	localparam logic [20:0] GAP35 = 21'(BIT_CYC * `MB_GAP35_HALF_BITS / 2);
	localparam logic [20:0] LAT_MAX = 21'(REPLY_LAT_CYC - 1);

	function automatic logic mb_dt_valid(input logic [63:0] d);
		logic [7:0] dmax;
		begin
			case (d[47:40])
				8'h02: dmax = (d[49:48] == 2'b00) ? 8'h1d : 8'h1c;
				8'h04, 8'h06, 8'h09, 8'h0b: dmax = 8'h1e;
				default: dmax = 8'h1f;
			endcase
			return d[47:40] != 8'h00 && d[47:40] <= `MB_MONTHS
				&& d[39:32] != 8'h00 && d[39:32] <= dmax
				&& d[31:24] < `MB_HOURS && d[23:16] < `MB_MINUTES
				&& d[15:0] < `MB_MS_PER_MIN;
		end
	endfunction

	logic [7:0] rxb [0:255];
	logic [7:0] txb [0:255];
	mb_state_t st_reg, st_next;
	mb_mode_t mode_reg, mode_next;
	logic [8:0] len_reg, len_next, idx_reg, idx_next, tlen_reg, tlen_next;
	logic [20:0] gap_reg, gap_next, lat_reg, lat_next;
	logic bad_reg, bad_next, dtok_reg, dtok_next, rearm;
	logic [15:0] rcrc_reg, rcrc_next, tcrc_reg, tcrc_next, rx_crc, tx_crc;
	logic [15:0] rda_reg, rda_next, cnt;
	logic [7:0] left_reg, left_next, exc_reg, exc_next, lo_reg, lo_next;
	logic [7:0] fill_src, tx_src, idi_next;
	logic [63:0] snap_reg, snap_next, dtset, dtv_next;
	logic [8:0] fill_last;
	logic rxb_we, txb_we, req_next, dtl_next, tx_start, cerr_set, ferr_set;
	logic good_inc;
	logic [7:0] rxb_wi, txb_wi, txb_wd;
	logic rx_valid, rx_err, tx_done;
	logic [7:0] rx_data;
	logic [7:0] own_reg, own_next;
	logic cerr_reg, cerr_next, ferr_reg, ferr_next;
	logic [15:0] good_reg, good_next;
	logic [31:0] rdata_next;

	mb_uart #(.BIT_CYC(BIT_CYC)) u_uart
	(
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.rx_in(rx_in),
		.tx_data_in(tx_src),
		.tx_start_in(tx_start),
		.rx_valid_out(rx_valid),
		.rx_data_out(rx_data),
		.rx_err_out(rx_err),
		.tx_out(tx_out),
		.tx_done_out(tx_done)
	);
	mb_crc u_rx_crc
	(
		.crc_in(rcrc_reg),
		.data_in(rx_data),
		.crc_out(rx_crc)
	);
	mb_crc u_tx_crc
	(
		.crc_in(tcrc_reg),
		.data_in(tx_src),
		.crc_out(tx_crc)
	);

	// driver enable only while a reply is on the line
	assign tx_en_out = (st_reg == ST_TX) || (st_reg == ST_TXWAIT);

	// =============================================================
	// frame handling
	always_comb
	begin
		st_next = st_reg;
		mode_next = mode_reg;
		len_next = len_reg;
		idx_next = idx_reg;
		tlen_next = tlen_reg;
		gap_next = gap_reg;
		lat_next = lat_reg;
		bad_next = bad_reg;
		dtok_next = dtok_reg;
		rcrc_next = rcrc_reg;
		tcrc_next = tcrc_reg;
		rda_next = rda_reg;
		left_next = left_reg;
		exc_next = exc_reg;
		lo_next = lo_reg;
		snap_next = snap_reg;
		dtv_next = dt_value_out;
		idi_next = id_index_out;
		req_next = 1'b0;
		dtl_next = 1'b0;
		tx_start = 1'b0;
		cerr_set = 1'b0;
		ferr_set = 1'b0;
		good_inc = 1'b0;
		rearm = 1'b0;
		rxb_we = 1'b0;
		rxb_wi = len_reg[7:0];
		txb_we = 1'b0;
		txb_wi = idx_reg[7:0];
		txb_wd = 8'h00;
		cnt = {rxb[4], rxb[5]};
		dtset = {rxb[4], rxb[5], rxb[6], rxb[7], rxb[8], rxb[9], rxb[10],
			rxb[11]};
		fill_last = (mode_reg == M_RDH) ? 9'h002 : tlen_reg - 9'h001;
		case (mode_reg)
			M_EXC: fill_src = (idx_reg == 9'h000) ? rxb[0] :
				(idx_reg == 9'h001) ? (rxb[1] | `MB_FC_EXC_BIT) : exc_reg;
			M_RDH: fill_src = (idx_reg < 9'h002) ? rxb[idx_reg[7:0]] :
				{left_reg[6:0], 1'b0};
			M_ID: fill_src = (idx_reg < `MB_LEN_HDR) ? rxb[idx_reg[7:0]] :
				id_byte_in;
			M_DTGET: fill_src = (idx_reg < `MB_LEN_HDR) ? rxb[idx_reg[7:0]] :
				(idx_reg == `MB_LEN_HDR) ? `MB_RSVD :
				snap_reg[{3'd7 - 3'(idx_reg[2:0] - 3'd4), 3'b000} +: 8];
			default: fill_src = (idx_reg < `MB_DT_OFS || dtok_reg) ?
				rxb[idx_reg[7:0]] : 8'h00;
		endcase
		if (idx_reg < tlen_reg)
			tx_src = txb[idx_reg[7:0]];
		else if (idx_reg == tlen_reg)
			tx_src = tcrc_reg[7:0];
		else
			tx_src = tcrc_reg[15:8];
		case (st_reg)
			ST_RX:
			begin
				if (rx_valid)
				begin
					gap_next = 21'h000000;
					if (len_reg == `MB_FRAME_MAX || rx_err
						|| (gap_reg >= GAP15 && len_reg != 9'h000))
						bad_next = 1'b1;
					else
					begin
						rxb_we = 1'b1;
						len_next = len_reg + 9'h001;
						rcrc_next = rx_crc;
					end
				end
				else if (gap_reg != GAP35)
					gap_next = gap_reg + 21'h000001;
				else if (len_reg != 9'h000)
				begin
					if (bad_reg || len_reg < `MB_LEN_MIN)
					begin
						ferr_set = 1'b1;
						rearm = 1'b1;
					end
					else if (rcrc_reg != `MB_CRC_RESIDUE)
					begin
						cerr_set = 1'b1;
						rearm = 1'b1;
					end
					else if (rxb[0] == own_reg || rxb[0] == `MB_ADDR_BCAST)
					begin
						st_next = ST_DECODE;
						good_inc = 1'b1;
					end
					else
						rearm = 1'b1;
				end
			end
			ST_DECODE:
			begin
				idx_next = 9'h000;
				idi_next = 8'hfd;
				lat_next = 21'h000000;
				tcrc_next = `MB_CRC_INIT;
				st_next = ST_FILL;
				mode_next = M_EXC;
				tlen_next = `MB_LEN_HDR;
				exc_next = `MB_EX_FUNC;
				if (rxb[1] == `MB_FC_RD_HOLD)
				begin
					if (len_reg != `MB_LEN_RD_HOLD || cnt == 16'h0000
						|| cnt > `MB_RD_MAX)
						exc_next = `MB_EX_VALUE;
					else
					begin
						mode_next = M_RDH;
						tlen_next = `MB_LEN_HDR + {cnt[7:0], 1'b0};
						rda_next = {rxb[2], rxb[3]};
						left_next = cnt[7:0];
					end
				end
				else if (rxb[1] == `MB_FC_MEI && rxb[2] == `MB_SUB_ID)
				begin
					mode_next = M_ID;
					tlen_next = `MB_LEN_HDR + `MB_ID_LEN;
				end
				else if (rxb[1] == `MB_FC_MEI && rxb[2] == `MB_SUB_DT_GET)
				begin
					mode_next = M_DTGET;
					tlen_next = `MB_LEN_DT_REPLY;
					snap_next = dt_now_in;
				end
				else if (rxb[1] == `MB_FC_MEI && rxb[2] == `MB_SUB_DT_SET)
				begin
					if (len_reg != `MB_LEN_DT_SET)
						exc_next = `MB_EX_VALUE;
					else
					begin
						mode_next = M_ECHO;
						tlen_next = `MB_LEN_DT_REPLY;
						dtok_next = mb_dt_valid(dtset);
						dtl_next = mb_dt_valid(dtset);
						if (mb_dt_valid(dtset))
							dtv_next = dtset;
					end
				end
				if (rxb[0] == `MB_ADDR_BCAST)
				begin
					st_next = ST_RX;
					rearm = 1'b1;
				end
			end
			ST_FILL:
			begin
				txb_we = 1'b1;
				txb_wd = fill_src;
				idx_next = idx_reg + 9'h001;
				idi_next = id_index_out + 8'h01;
				if (idx_reg == fill_last)
				begin
					if (mode_reg == M_RDH)
						st_next = ST_RDREQ;
					else
					begin
						st_next = ST_TX;
						idx_next = 9'h000;
					end
				end
			end
			ST_RDREQ:
			begin
				req_next = 1'b1;
				st_next = ST_RDWAIT;
			end
			ST_RDWAIT:
			begin
				lat_next = lat_reg + 21'h000001;
				if (hreg_ack_in)
				begin
					if (hreg_err_in)
					begin
						mode_next = M_EXC;
						exc_next = `MB_EX_ADDR;
						tlen_next = `MB_LEN_HDR;
						idx_next = 9'h000;
						st_next = ST_FILL;
					end
					else
					begin
						txb_we = 1'b1;
						txb_wd = hreg_data_in[15:8];
						lo_next = hreg_data_in[7:0];
						idx_next = idx_reg + 9'h001;
						st_next = ST_RDLO;
					end
				end
				else if (lat_reg == LAT_MAX)
				begin
					mode_next = M_EXC;
					exc_next = `MB_EX_FAIL;
					tlen_next = `MB_LEN_HDR;
					idx_next = 9'h000;
					st_next = ST_FILL;
				end
			end
			ST_RDLO:
			begin
				txb_we = 1'b1;
				txb_wd = lo_reg;
				idx_next = idx_reg + 9'h001;
				rda_next = rda_reg + 16'h0001;
				left_next = left_reg - 8'h01;
				st_next = ST_RDREQ;
				if (left_reg == 8'h01)
				begin
					idx_next = 9'h000;
					st_next = ST_TX;
				end
			end
			ST_TX:
			begin
				tx_start = 1'b1;
				if (idx_reg < tlen_reg)
					tcrc_next = tx_crc;
				st_next = ST_TXWAIT;
			end
			default:
			begin
				if (tx_done)
				begin
					idx_next = idx_reg + 9'h001;
					st_next = ST_TX;
					if (idx_reg == tlen_reg + 9'h001)
					begin
						st_next = ST_RX;
						rearm = 1'b1;
					end
				end
			end
		endcase
		if (rearm)
		begin
			len_next = 9'h000;
			bad_next = 1'b0;
			gap_next = 21'h000000;
			rcrc_next = `MB_CRC_INIT;
		end
	end

	always_ff @(posedge ref_clk_in)
	begin
		if (rxb_we)
			rxb[rxb_wi] <= rx_data;
		if (txb_we)
			txb[txb_wi] <= txb_wd;
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			st_reg <= ST_RX;
			mode_reg <= M_EXC;
			len_reg <= 9'h000;
			idx_reg <= 9'h000;
			tlen_reg <= 9'h000;
			gap_reg <= 21'h000000;
			lat_reg <= 21'h000000;
			bad_reg <= 1'b0;
			dtok_reg <= 1'b0;
			rcrc_reg <= `MB_CRC_INIT;
			tcrc_reg <= `MB_CRC_INIT;
			rda_reg <= 16'h0000;
			left_reg <= 8'h00;
			exc_reg <= 8'h00;
			lo_reg <= 8'h00;
			snap_reg <= 64'h0000000000000000;
			dt_value_out <= 64'h0000000000000000;
			dt_load_out <= 1'b0;
			id_index_out <= 8'h00;
			hreg_req_out <= 1'b0;
		end
		else
		begin
			st_reg <= st_next;
			mode_reg <= mode_next;
			len_reg <= len_next;
			idx_reg <= idx_next;
			tlen_reg <= tlen_next;
			gap_reg <= gap_next;
			lat_reg <= lat_next;
			bad_reg <= bad_next;
			dtok_reg <= dtok_next;
			rcrc_reg <= rcrc_next;
			tcrc_reg <= tcrc_next;
			rda_reg <= rda_next;
			left_reg <= left_next;
			exc_reg <= exc_next;
			lo_reg <= lo_next;
			snap_reg <= snap_next;
			dt_value_out <= dtv_next;
			dt_load_out <= dtl_next;
			id_index_out <= idi_next;
			hreg_req_out <= req_next;
		end
	end

	assign hreg_addr_out = rda_reg;

	// =============================================================
	// software registers
	always_comb
	begin
		own_next = own_reg;
		good_next = good_inc ? good_reg + 16'h0001 : good_reg;
		cerr_next = cerr_reg;
		ferr_next = ferr_reg;
		rdata_next = 32'h00000000;
		if (reg_wr_in && reg_addr_in == `MB_REG_SLAVE_ADDR)
		begin
			if (reg_wdata_in[7:0] != `MB_ADDR_BCAST
				&& reg_wdata_in[7:0] <= `MB_ADDR_MAX && reg_wdata_in[31:8] == 24'h0)
				own_next = reg_wdata_in[7:0];
		end
		else if (reg_wr_in && reg_addr_in == `MB_REG_STATUS)
		begin
			if (reg_wdata_in[`MB_ST_CRC_ERR])
				cerr_next = 1'b0;
			if (reg_wdata_in[`MB_ST_FRAME_ERR])
				ferr_next = 1'b0;
		end
		// a new error in the clearing cycle is kept
		if (cerr_set)
			cerr_next = 1'b1;
		if (ferr_set)
			ferr_next = 1'b1;
		if (reg_rd_in && reg_addr_in == `MB_REG_SLAVE_ADDR)
			rdata_next = {24'h000000, own_reg};
		else if (reg_rd_in && reg_addr_in == `MB_REG_STATUS)
			rdata_next = {29'h00000000, st_reg != ST_RX, ferr_reg, cerr_reg};
		else if (reg_rd_in && reg_addr_in == `MB_REG_GOOD_FRAMES)
			rdata_next = {16'h0000, good_reg};
	end

	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			own_reg <= `MB_ADDR_RESET;
			good_reg <= 16'h0000;
			cerr_reg <= 1'b0;
			ferr_reg <= 1'b0;
			reg_rdata_out <= 32'h00000000;
		end
		else
		begin
			own_reg <= own_next;
			good_reg <= good_next;
			cerr_reg <= cerr_next;
			ferr_reg <= ferr_next;
			reg_rdata_out <= rdata_next;
		end
	end
endmodule
`default_nettype wire

// File: dv/mb_slave_asserts.sv
// port checks for the serial slave request handler
`timescale 1ns/100ps
`default_nettype none
module mb_slave_asserts
#(
	parameter int BIT_CYC = 16,
	parameter int REPLY_LAT_CYC = 200
)
(
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic rx_in,
	input wire logic tx_out,
	input wire logic tx_en_out,
	input wire logic hreg_req_out,
	input wire logic [15:0] hreg_addr_out,
	input wire logic hreg_ack_in,
	input wire logic dt_load_out
);
	localparam int GAP35 = BIT_CYC * 77 / 2;
	logic [31:0] quiet_reg, quiet_next;
	logic [31:0] lat_reg, lat_next;
	logic wait_reg, wait_next;
	// ==========
	// line silence and pending register read
	always_comb
	begin
		quiet_next = 32'h00000000;
		if (rx_in)
			quiet_next = quiet_reg + {31'h00000000, quiet_reg != 32'hffffffff};
		// a read given up for an exception no longer counts
		wait_next = hreg_req_out | (wait_reg & ~hreg_ack_in & ~tx_en_out);
		lat_next = wait_next ? lat_reg + 32'h1 : 32'h0;
	end
	always_ff @(posedge ref_clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			quiet_reg <= 32'h00000000;
			lat_reg <= 32'h0;
			wait_reg <= 1'b0;
		end
		else
		begin
			quiet_reg <= quiet_next;
			lat_reg <= lat_next;
			wait_reg <= wait_next;
		end
	end
	default clocking @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);
	AST_IDLE_HIGH: assert property (!tx_en_out |-> tx_out)
		else $error("line not idle outside a reply");
	AST_QUIET_FIRST: assert property ($rose(tx_en_out) |-> quiet_reg >= GAP35)
		else $error("reply started before the frame gap");
	AST_START_BIT: assert property ($rose(tx_en_out) |-> ##[1:4] !tx_out)
		else $error("no start bit after driver enable");
	AST_REQ_PULSE: assert property (hreg_req_out |=> !hreg_req_out)
		else $error("register request longer than one cycle");
	AST_ADDR_HOLD: assert property (wait_reg |-> $stable(hreg_addr_out))
		else $error("register address moved while pending");
	AST_NO_READ_IN_REPLY: assert property (tx_en_out |-> !hreg_req_out)
		else $error("register read while replying");
	AST_LOAD_FIRST: assert property (dt_load_out |-> !tx_en_out ##1 !dt_load_out)
		else $error("clock load not a pulse ahead of reply");
	AST_LATENCY: assert property (lat_reg <= REPLY_LAT_CYC + 8)
		else $error("register wait beyond reply bound");
endmodule
bind mb_slave mb_slave_asserts #(
	.BIT_CYC(BIT_CYC),
	.REPLY_LAT_CYC(REPLY_LAT_CYC)
) u_chk (.ref_clk_in, .rst_in, .rx_in, .tx_out, .tx_en_out, .hreg_req_out,
	.hreg_addr_out, .hreg_ack_in, .dt_load_out);
`default_nettype wire

// File: dv/mb_master_model.sv
// bus master stand-in: sends requests, captures replies
`timescale 1ns/100ps
`default_nettype none
module mb_master_model
#(
	parameter int BIT_CYC = 16
)
(
	input wire logic ref_clk_in,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] rxq[$];
	int perr;
	initial
	begin
		line_out = 1'b1;
		perr = 0;
	end
	// ==========
	// sole master, bytes back to back, 8E2
	task automatic send(input logic [7:0] f[$]);
		logic [11:0] w;
		foreach (f[i])
		begin
			w = {2'b11, ^f[i], f[i], 1'b0};
			for (int b = 0; b < 12; b++)
			begin
				line_out <= w[b];
				repeat (BIT_CYC) @(posedge ref_clk_in);
			end
		end
	endtask
	// reply capture, sampled mid-bit
	always
	begin
		logic [10:0] r;
		@(negedge line_in);
		repeat (BIT_CYC / 2) @(posedge ref_clk_in);
		for (int b = 0; b < 11; b++)
		begin
			repeat (BIT_CYC) @(posedge ref_clk_in);
			r[b] = line_in;
		end
		if (^r[8:0] || r[10:9] !== 2'b11)
			perr++;
		rxq.push_back(r[7:0]);
	end
endmodule
`default_nettype wire

// File: dv/mb_slave_tb.sv
// self-checking bench for the serial slave request handler
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, a, e) begin num_checks++; if ((a) !== (e)) begin \
	miscompares++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
	end end
module mb_slave_tb;
	logic ref_clk_in, rst_in, rx_in, tx_out, tx_en_out;
	logic [7:0] reg_addr_in, id_index_out, id_byte_in;
	logic [31:0] reg_wdata_in, reg_rdata_out;
	logic reg_wr_in, reg_rd_in, hreg_req_out, hreg_ack_in, hreg_err_in;
	logic [15:0] hreg_addr_out, hreg_data_in;
	logic [63:0] dt_now_in, dt_value_out, last_dt;
	logic dt_load_out;
	logic [1:0] hmode;
	int miscompares, num_checks, cycles, loads, tn;
	mb_slave #(.BIT_CYC(16), .REPLY_LAT_CYC(200)) uut (.ref_clk_in, .rst_in,
		.rx_in, .tx_out, .tx_en_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .hreg_req_out, .hreg_addr_out,
		.hreg_ack_in, .hreg_err_in, .hreg_data_in, .id_index_out,
		.id_byte_in, .dt_now_in, .dt_load_out, .dt_value_out);
	mb_master_model #(.BIT_CYC(16)) m (.ref_clk_in(ref_clk_in),
		.line_in(tx_out), .line_out(rx_in));
	always #4 ref_clk_in = ~ref_clk_in;
	assign id_byte_in = id_index_out ^ 8'h5a;
	// ==========
	// register store answers the cycle after a request, except with hmode 2, where it never answers
	always @(posedge ref_clk_in)
	begin
		if (dt_load_out)
		begin
			loads++;
			last_dt <= dt_value_out;
		end
		hreg_ack_in <= hreg_req_out && hmode != 2'h2;
		hreg_err_in <= hmode == 2'h1;
		hreg_data_in <= hreg_req_out ? hreg_addr_out ^ 16'h5a3c : ~hreg_data_in;
		cycles++;
		if (cycles == 95000)
		begin
			miscompares++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
		@(posedge ref_clk_in);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		@(negedge ref_clk_in);
		`CHK("reg_rdata", reg_rdata_out, e)
		@(posedge ref_clk_in);
	endtask
	function automatic void crc_add(ref logic [7:0] q[$], input logic bad);
		logic [15:0] c;
		c = 16'hffff;
		foreach (q[i])
		begin
			c ^= {8'h00, q[i]};
			repeat (8)
				c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		q.push_back(c[7:0] ^ {7'h00, bad});
		q.push_back(c[15:8]);
	endfunction
	// k of zero means no reply may appear in the window
	task automatic run(input int n, input logic [95:0] v, input int k,
		input logic [95:0] x, input logic bad);
		logic [7:0] q[$];
		logic [7:0] e[$];
		int t;
		for (int i = 0; i < n; i++)
			q.push_back(v[8 * (n - 1 - i) +: 8]);
		for (int i = 0; i < k; i++)
			e.push_back(x[8 * (k - 1 - i) +: 8]);
		crc_add(q, bad);
		if (k > 0)
			crc_add(e, 1'b0);
		m.rxq.delete();
		m.send(q);
		for (t = 0; t < 4000 && m.rxq.size() < (k > 0 ? k + 2 : 1); t++)
			@(posedge ref_clk_in);
		for (t = 0; t < 200 && tx_en_out !== 1'b0; t++)
			@(posedge ref_clk_in);
		`CHK("reply_len", m.rxq.size(), e.size())
		foreach (e[i])
			`CHK("reply_byte", m.rxq[i], e[i])
		tn++;
		$display("test %0d done", tn);
	endtask
	initial
	begin
		ref_clk_in = 1'b0;
		rst_in = 1'b1;
		reg_addr_in = 8'h00;
		reg_wdata_in = 32'h0;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		dt_now_in = 64'h000e0a020e200dac;
		hmode = 2'h0;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		rd(8'h00, 32'h00000001);
		wr(8'h00, 32'h00000000);
		wr(8'h00, 32'h000000f8);
		rd(8'h00, 32'h00000001);
		rd(8'h0c, 32'h00000000);
		wr(8'h00, 32'h00000002);
		run(6, 96'h010307cf0001, 0, 96'h0, 1'b0);
		wr(8'h00, 32'h00000001);
		run(6, 96'h010307cf0002, 7, 96'h0103045df35dec, 1'b0);
		run(6, 96'h000307cf0001, 0, 96'h0, 1'b0);
		run(6, 96'h050300000001, 0, 96'h0, 1'b0);
		run(6, 96'h010307cf0001, 0, 96'h0, 1'b1);
		rd(8'h04, 32'h00000001);
		wr(8'h04, 32'h00000001);
		rd(8'h04, 32'h00000000);
		run(3, 96'h012b0e, 11, 96'h012b0e5a5b58595e5f5c5d, 1'b0);
		run(4, 96'h012b0f00, 12, 96'h012b0f00000e0a020e200dac, 1'b0);
		run(12, 96'h012b1000000e0a020e200dac, 12,
			96'h012b1000000e0a020e200dac, 1'b0);
		`CHK("dt_loads", loads, 1)
		`CHK("dt_value", last_dt, 64'h000e0a020e200dac)
		run(12, 96'h012b1000000e0d020e200dac, 12,
			96'h012b10000000000000000000, 1'b0);
		`CHK("dt_loads", loads, 1)
		run(6, 96'h010500000001, 3, 96'h018501, 1'b0);
		run(6, 96'h010300000000, 3, 96'h018303, 1'b0);
		hmode <= 2'h1;
		run(6, 96'h010300100001, 3, 96'h018302, 1'b0);
		hmode <= 2'h2;
		run(6, 96'h010300100001, 3, 96'h018304, 1'b0);
		hmode <= 2'h0;
		run(12, 96'h002b1000000e0a020e200dac, 0, 96'h0, 1'b0);
		`CHK("dt_loads", loads, 2)
		rd(8'h08, 32'h0000000b);
		`CHK("line_format", m.perr, 0)
		// supply loss and return: reset mid-run, then clocks are rewritten
		rst_in <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		@(posedge ref_clk_in);
		rd(8'h00, 32'h00000001);
		run(12, 96'h002b1000000e0a020e200dac, 0, 96'h0, 1'b0);
		`CHK("dt_loads", loads, 3)
		rd(8'h08, 32'h00000001);
		close_out();
	end
endmodule
`default_nettype wire
